// ### ppfc_map.svh
// register map, reset values and pin layout of the port pin block
`ifndef PPFC_MAP_SVH
`define PPFC_MAP_SVH

// ==========================================================
// pin totals and port groups
// order: 0 1 2 3 4 5 7 8 AL AH DL CS CT CM CD BD
`define PPFC_PIN_COUNT    112
`define PPFC_IN_ONLY      11
`define PPFC_GROUPS       16
`define PPFC_GROUP_WIDTHS '{8, 8, 8, 8, 8, 8, 8, 3, 8, 8, 8, 8, 8, 4, 4, 5}
`define PPFC_HAS_DIR      16'hFF3F
`define PPFC_HAS_MODE     16'hFF7F
`define PPFC_HAS_FSEL     16'h183F
`define PPFC_HAS_FSELX    16'h002F

// ==========================================================
// address map: group * 8 + register kind
`define PPFC_REG_DATA     3'h0
`define PPFC_REG_DIR      3'h1
`define PPFC_REG_MODE     3'h2
`define PPFC_REG_FSELX    3'h3
`define PPFC_REG_FSEL     3'h4
`define PPFC_ADDR_STATUS  8'h80

// ==========================================================
// reset values
`define PPFC_RST_DATA     8'h00
`define PPFC_RST_DIR      8'hFF
`define PPFC_RST_MODE     8'h00
`define PPFC_RST_FSELX    8'h00
`define PPFC_RST_FSEL     8'h00

// ==========================================================
// field positions
`define PPFC_P0_TMS_BIT   6
`define PPFC_P0_TCK_BIT   7
`define PPFC_ST_TRST_BIT  0
`define PPFC_ST_BAD_BIT   1

`endif

// ### ppfc_pkg.sv
// types shared by the port pin function blocks
`include "ppfc_map.svh"

package ppfc_pkg;

  // pin 0 alternate choice: {extension select, function select}
  typedef enum logic [1:0] {
    PPFC_P0_INTR  = 2'h0,
    PPFC_P0_TIMER = 2'h1,
    PPFC_P0_EVENT = 2'h2,
    PPFC_P0_BAD   = 2'h3
  } ppfc_p0fn_t;

endpackage : ppfc_pkg

// ### ppfc_sync.sv
// two flip-flop synchroniser for pin levels
`timescale 1ns/1ps
`include "ppfc_map.svh"

module ppfc_sync
  import ppfc_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  // meta is read by q alone
  always_comb begin
    next_meta = d;
    next_q    = meta;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= next_meta;
      q    <= next_q;
    end
  end

endmodule : ppfc_sync

// ### ppfc_group.sv
// one port group: latch, direction, mode and select registers
`timescale 1ns/1ps
`include "ppfc_map.svh"

module ppfc_group
  import ppfc_pkg::*;
#(
  parameter int W         = 8,
  parameter bit HAS_DIR   = 1'b1,
  parameter bit HAS_MODE  = 1'b1,
  parameter bit HAS_FSEL  = 1'b1,
  parameter bit HAS_FSELX = 1'b1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         wr_en,
  input  wire logic [2:0]   wr_reg,
  input  wire logic [7:0]   wdata,
  input  wire logic [7:0]   bit_en,
  input  wire logic [W-1:0] pin_level,
  input  wire logic [W-1:0] alt_out,
  input  wire logic [W-1:0] hold_off,
  output logic      [7:0]   data_rd,
  output logic      [7:0]   dir_rd,
  output logic      [7:0]   mode_rd,
  output logic      [7:0]   fselx_rd,
  output logic      [7:0]   fsel_rd,
  output logic      [W-1:0] pin_out,
  output logic      [W-1:0] pin_oe_n
);

  if (W < 1 || W > 8) begin : g_bad_width
    $error("group width must be 1 to 8");
  end

  logic [W-1:0] latch, dir, mode, fselx, fsel;
  logic [W-1:0] next_latch, next_dir, next_mode, next_fselx, next_fsel;
  logic [W-1:0] be, wd, in_mode, drive_val, rd_val;

  // bit-masked update; absent registers keep their reset value
  always_comb begin
    be         = bit_en[W-1:0];
    wd         = wdata[W-1:0];
    next_latch = latch;
    next_dir   = dir;
    next_mode  = mode;
    next_fselx = fselx;
    next_fsel  = fsel;
    if (wr_en) begin
      case (wr_reg)
        `PPFC_REG_DATA:  next_latch = (latch & ~be) | (wd & be);
        `PPFC_REG_DIR:   if (HAS_DIR) next_dir = (dir & ~be) | (wd & be);
        `PPFC_REG_MODE:  if (HAS_MODE) next_mode = (mode & ~be) | (wd & be);
        `PPFC_REG_FSELX: if (HAS_FSELX) next_fselx = (fselx & ~be) | (wd & be);
        `PPFC_REG_FSEL:  if (HAS_FSEL) next_fsel = (fsel & ~be) | (wd & be);
        default:         next_latch = latch;
      endcase
    end
  end

  // per pin drive and readback
  for (genvar b = 0; b < W; b++) begin : g_bit
    assign in_mode[b]   = dir[b] | hold_off[b];
    assign drive_val[b] = mode[b] ? alt_out[b] : latch[b];
    assign rd_val[b]    = in_mode[b] ? pin_level[b] : drive_val[b];
  end

  // latch is never touched by mode changes, only by data writes
  always_ff @(posedge clk) begin
    if (rst) begin
      latch    <= W'(`PPFC_RST_DATA);
      dir      <= W'(`PPFC_RST_DIR);
      mode     <= W'(`PPFC_RST_MODE);
      fselx    <= W'(`PPFC_RST_FSELX);
      fsel     <= W'(`PPFC_RST_FSEL);
      pin_out  <= '0;
      pin_oe_n <= '1;
    end else begin
      latch    <= next_latch;
      dir      <= next_dir;
      mode     <= next_mode;
      fselx    <= next_fselx;
      fsel     <= next_fsel;
      pin_out  <= drive_val;
      pin_oe_n <= in_mode;
    end
  end

  assign data_rd  = 8'(rd_val);
  // an absent direction register reads as zero, like any unmapped place
  assign dir_rd   = HAS_DIR ? 8'(dir) : 8'h00;
  assign mode_rd  = 8'(mode);
  assign fselx_rd = 8'(fselx);
  assign fsel_rd  = 8'(fsel);

endmodule : ppfc_group

// ### ppfc_top.sv
// port pin function control: all port groups, register port, debug takeover
`timescale 1ns/1ps
`include "ppfc_map.svh"

module ppfc_top
  import ppfc_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [7:0]   bus_addr,
  input  wire logic [7:0]   bus_wdata,
  input  wire logic [7:0]   bus_bit_en,
  input  wire logic         bus_wr,
  input  wire logic         bus_rd,
  output logic      [7:0]   bus_rdata,
  input  wire logic [111:0] pin_in,
  output logic      [111:0] pin_out,
  output logic      [111:0] pin_oe_n,
  input  wire logic [111:0] alt_out,
  output logic      [111:0] alt_in,
  output logic      [111:0] alt_mode,
  output logic      [111:0] alt_fsel,
  output logic      [111:0] alt_fselx,
  input  wire logic         test_reset,
  output logic              debug_tms,
  output logic              debug_tck,
  input  wire logic         pin0_timer_output,
  output logic              pin0_interrupt_input,
  output logic              pin0_event_input,
  output logic              pin0_timer_input,
  output logic              pin0_capture_interrupt
);

  // ==========================================================
  // group layout
  localparam int NPIN   = `PPFC_PIN_COUNT;
  localparam int GROUPS = `PPFC_GROUPS;
  localparam int GW [GROUPS] = `PPFC_GROUP_WIDTHS;
  localparam logic [GROUPS-1:0] G_DIR   = `PPFC_HAS_DIR;
  localparam logic [GROUPS-1:0] G_MODE  = `PPFC_HAS_MODE;
  localparam logic [GROUPS-1:0] G_FSEL  = `PPFC_HAS_FSEL;
  localparam logic [GROUPS-1:0] G_FSELX = `PPFC_HAS_FSELX;

  // first pin of a group in the flat pin vectors
  function automatic int base_of(int g);
    int s;
    s = 0;
    for (int i = 0; i < g; i++) begin
      s += GW[i];
    end
    return s;
  endfunction : base_of

  // pins of groups with no direction register
  function automatic int in_only_count();
    int s;
    s = 0;
    for (int i = 0; i < GROUPS; i++) begin
      if (!G_DIR[i]) begin
        s += GW[i];
      end
    end
    return s;
  endfunction : in_only_count

  // the layout must add up to the documented pin split
  if (base_of(GROUPS) != NPIN) begin : g_bad_total
    $error("group widths do not add up to the pin count");
  end
  if (in_only_count() != `PPFC_IN_ONLY) begin : g_bad_inonly
    $error("input-only pin count is wrong");
  end

  // ==========================================================
  // pin synchronisers
  logic [NPIN-1:0] pin_s;
  logic            tst_s;

  // test reset and every pin cross in together
  ppfc_sync #(
    .W (NPIN + 1)
  ) u_sync (
    .clk (clk),
    .rst (rst),
    .d   ({test_reset, pin_in}),
    .q   ({tst_s, pin_s})
  );

  // ==========================================================
  // bus decode
  logic [3:0]        grp;
  logic [2:0]        kind;
  logic [GROUPS-1:0] g_wr;

  assign grp  = bus_addr[6:3];
  assign kind = bus_addr[2:0];

  // ==========================================================
  // pin 0 alternate choice and debug takeover
  ppfc_p0fn_t      p0_code;
  logic            p0_bad;
  logic [NPIN-1:0] hold_all;
  logic [NPIN-1:0] aout_all;
  logic [NPIN-1:0] dir_all;

  // prohibited code leaves pin 0 undriven rather than guessing
  always_comb begin
    p0_code  = ppfc_p0fn_t'({alt_fselx[0], alt_fsel[0]});
    p0_bad   = alt_mode[0] && (p0_code == PPFC_P0_BAD);
    hold_all = '0;
    hold_all[0] = p0_bad;
    hold_all[`PPFC_P0_TMS_BIT] = tst_s;
    hold_all[`PPFC_P0_TCK_BIT] = tst_s;
    aout_all = alt_out;
    aout_all[0] = (p0_code == PPFC_P0_TIMER) ? pin0_timer_output : 1'b0;
  end

  // ==========================================================
  // port groups
  logic [7:0] g_data  [GROUPS];
  logic [7:0] g_dir   [GROUPS];
  logic [7:0] g_mode  [GROUPS];
  logic [7:0] g_fselx [GROUPS];
  logic [7:0] g_fsel  [GROUPS];

  // register existence per group follows the layout masks
  for (genvar g = 0; g < GROUPS; g++) begin : g_grp
    localparam int B = base_of(g);
    localparam int W = GW[g];

    assign g_wr[g] = bus_wr && !bus_addr[7] && (grp == 4'(g));

    ppfc_group #(
      .W         (W),
      .HAS_DIR   (G_DIR[g]),
      .HAS_MODE  (G_MODE[g]),
      .HAS_FSEL  (G_FSEL[g]),
      .HAS_FSELX (G_FSELX[g])
    ) u_grp (
      .clk       (clk),
      .rst       (rst),
      .wr_en     (g_wr[g]),
      .wr_reg    (kind),
      .wdata     (bus_wdata),
      .bit_en    (bus_bit_en),
      .pin_level (pin_s[B +: W]),
      .alt_out   (aout_all[B +: W]),
      .hold_off  (hold_all[B +: W]),
      .data_rd   (g_data[g]),
      .dir_rd    (g_dir[g]),
      .mode_rd   (g_mode[g]),
      .fselx_rd  (g_fselx[g]),
      .fsel_rd   (g_fsel[g]),
      .pin_out   (pin_out[B +: W]),
      .pin_oe_n  (pin_oe_n[B +: W])
    );

    // settings fan out to the peripherals sharing the pins
    assign alt_mode[B +: W]  = g_mode[g][W-1:0];
    assign alt_fsel[B +: W]  = g_fsel[g][W-1:0];
    assign alt_fselx[B +: W] = g_fselx[g][W-1:0];
    // no direction register: the group is input-only, so its pins count as inputs
    assign dir_all[B +: W]   = G_DIR[g] ? g_dir[g][W-1:0] : {W{1'b1}};
  end

  // ==========================================================
  // read data, alternate inputs and debug outputs
  logic [7:0]      status;
  logic [7:0]      rd_val;
  logic [7:0]      next_rdata;
  logic [NPIN-1:0] next_alt_in;
  logic            next_tms;
  logic            next_tck;
  logic            next_p0_intr;
  logic            next_p0_event;

  always_comb begin
    status = 8'h00;
    status[`PPFC_ST_TRST_BIT] = tst_s;
    status[`PPFC_ST_BAD_BIT]  = p0_bad;
    rd_val = 8'h00;
    if (bus_addr == `PPFC_ADDR_STATUS) begin
      rd_val = status;
    end else if (!bus_addr[7]) begin
      case (kind)
        `PPFC_REG_DATA:  rd_val = g_data[grp];
        `PPFC_REG_DIR:   rd_val = g_dir[grp];
        `PPFC_REG_MODE:  rd_val = g_mode[grp];
        `PPFC_REG_FSELX: rd_val = g_fselx[grp];
        `PPFC_REG_FSEL:  rd_val = g_fsel[grp];
        default:         rd_val = 8'h00;
      endcase
    end
    // read data stand for one cycle only
    next_rdata = bus_rd ? rd_val : 8'h00;
    // only alternate-input pins reach peripherals; debug pins held off
    next_alt_in = pin_s & alt_mode & dir_all & ~hold_all;
    next_tms = tst_s & pin_s[`PPFC_P0_TMS_BIT];
    next_tck = tst_s & pin_s[`PPFC_P0_TCK_BIT];
    next_p0_intr  = next_alt_in[0] && (p0_code == PPFC_P0_INTR);
    next_p0_event = next_alt_in[0] && (p0_code == PPFC_P0_EVENT);
  end

  // one register stage; adds a cycle to the debug clock path
  always_ff @(posedge clk) begin
    if (rst) begin
      bus_rdata              <= 8'h00;
      alt_in                 <= '0;
      debug_tms              <= 1'b0;
      debug_tck              <= 1'b0;
      pin0_interrupt_input   <= 1'b0;
      pin0_event_input       <= 1'b0;
      pin0_timer_input       <= 1'b0;
      pin0_capture_interrupt <= 1'b0;
    end else begin
      bus_rdata              <= next_rdata;
      alt_in                 <= next_alt_in;
      debug_tms              <= next_tms;
      debug_tck              <= next_tck;
      pin0_interrupt_input   <= next_p0_intr;
      pin0_event_input       <= next_p0_event;
      pin0_timer_input       <= next_p0_event;
      pin0_capture_interrupt <= next_p0_event;
    end
  end

endmodule : ppfc_top

// ### ppfc_checker.sv
// assertion checker for the port pin block
`timescale 1ns/1ps

module ppfc_checker (
  input wire logic         clk,
  input wire logic         rst,
  input wire logic [7:0]   bus_addr,
  input wire logic         bus_rd,
  input wire logic [7:0]   bus_rdata,
  input wire logic [111:0] pin_out,
  input wire logic [111:0] pin_oe_n,
  input wire logic [111:0] alt_out,
  input wire logic [111:0] alt_in,
  input wire logic [111:0] alt_mode,
  input wire logic [111:0] alt_fsel,
  input wire logic [111:0] alt_fselx,
  input wire logic         test_reset,
  input wire logic         debug_tms,
  input wire logic         debug_tck,
  input wire logic         pin0_interrupt_input,
  input wire logic         pin0_event_input
);
  // ==========================================================
  // properties, all on the one clock
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_RDATA_IDLE: assert property (!$past(bus_rd) |-> bus_rdata == 8'h00)
    else $error("read data not zero outside a read");
  AST_IN_ONLY: assert property (pin_oe_n[58:48] == 11'h7FF)
    else $error("input-only pin driven");
  AST_NO_DIR: assert property (bus_rd && bus_addr == 8'h31 |=> bus_rdata == 8'h00)
    else $error("absent direction register read nonzero");
  AST_NO_MODE: assert property (bus_rd && bus_addr == 8'h3A |=> bus_rdata == 8'h00)
    else $error("absent mode register read nonzero");
  // sync chain makes the takeover lag by three edges
  AST_DBG_OE: assert property (test_reset [*5] |-> pin_oe_n[7:6] == 2'h3)
    else $error("debug pins still driven");
  AST_DBG_IDLE: assert property ((!test_reset) [*4] |-> !debug_tms && !debug_tck)
    else $error("debug outputs active without test reset");
  AST_ALT_IN: assert property ((alt_in & ~$past(alt_mode)) == 112'h0)
    else $error("alternate input on a port-mode pin");
  AST_INTR: assert property (pin0_interrupt_input |->
    $past(alt_mode[0]) && !$past(alt_fsel[0]) && !$past(alt_fselx[0]))
    else $error("interrupt input under wrong code");
  AST_EVENT: assert property (pin0_event_input |->
    $past(alt_mode[0]) && !$past(alt_fsel[0]) && $past(alt_fselx[0]))
    else $error("event input under wrong code");
  AST_BAD_CODE: assert property (alt_mode[0] && alt_fsel[0] && alt_fselx[0] |=>
    pin_oe_n[0])
    else $error("pin 0 driven under prohibited code");
  AST_ALT_OUT: assert property ($past(alt_mode[8]) && !pin_oe_n[8] |->
    pin_out[8] == $past(alt_out[8]))
    else $error("alternate output not on the pin");
endmodule : ppfc_checker

// ### ppfc_pin_world.sv
// far-side model: external devices on the pins
`timescale 1ns/1ps

module ppfc_pin_world (
  input  wire logic [111:0] pin_out,
  input  wire logic [111:0] pin_oe_n,
  input  wire logic [111:0] ext_level,
  output logic      [111:0] pin_in
);
  // ==========================================================
  // wire level: released pins show the device, never the stale output
  assign pin_in = (pin_out & ~pin_oe_n) | (ext_level & pin_oe_n);
endmodule : ppfc_pin_world

// ### tb_port_pin_function_control.sv
// testbench of the port pin block
`timescale 1ns/1ps

module tb_port_pin_function_control;
  import ppfc_pkg::*;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic [7:0]   bus_addr = 8'h00;
  logic [7:0]   bus_wdata = 8'h00;
  logic [7:0]   bus_bit_en = 8'h00;
  logic         bus_wr = 1'b0;
  logic         bus_rd = 1'b0;
  logic [7:0]   bus_rdata;
  logic [111:0] pin_in;
  logic [111:0] pin_out;
  logic [111:0] pin_oe_n;
  logic [111:0] alt_out = 112'h0;
  logic [111:0] alt_in;
  logic [111:0] alt_mode;
  logic [111:0] alt_fsel;
  logic [111:0] alt_fselx;
  logic [111:0] ext_level = 112'hA4;
  logic         test_reset = 1'b0;
  logic         debug_tms;
  logic         debug_tck;
  logic         pin0_timer_output = 1'b0;
  logic         pin0_interrupt_input;
  logic         pin0_event_input;
  logic         pin0_timer_input;
  logic         pin0_capture_interrupt;
  logic [7:0]   fn_exp [4] = '{8'h01, 8'h00, 8'h0E, 8'h00};
  logic [7:0]   gone [5] = '{8'h31, 8'h3A, 8'h23, 8'h34, 8'hF0};
  int           bad_count = 0;
  int           check_count = 0;
  int           cycles = 0;

  // ==========================================================
  // design, far side and clock
  ppfc_top i_ppfc_top (.clk, .rst, .bus_addr, .bus_wdata, .bus_bit_en, .bus_wr, .bus_rd,
    .bus_rdata, .pin_in, .pin_out, .pin_oe_n, .alt_out, .alt_in, .alt_mode, .alt_fsel,
    .alt_fselx, .test_reset, .debug_tms, .debug_tck, .pin0_timer_output,
    .pin0_interrupt_input, .pin0_event_input, .pin0_timer_input, .pin0_capture_interrupt);
  ppfc_pin_world i_ppfc_pin_world (.pin_out, .pin_oe_n, .ext_level, .pin_in);
  always #50 clk = ~clk;

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one-cycle strobes, launched right after an edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [7:0] be);
    @(posedge clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_bit_en <= be;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1;
    chk(bus_rdata, exp);
  endtask : rd

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wt

  // hang guard: the sequence needs about 150 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      finish_test();
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(8'h01, 8'hFF);
    rd(8'h02, 8'h00);
    rd(8'h00, 8'hA4);
    // single-bit writes, pin 0 driven from its latch
    wr(8'h00, 8'hFF, 8'h01);
    wr(8'h01, 8'h00, 8'h01);
    wt(2);
    chk({6'h00, pin_oe_n[1:0]}, 8'h02);
    chk({7'h00, pin_out[0]}, 8'h01);
    rd(8'h00, 8'hA5);
    rd(8'h01, 8'hFE);
    wr(8'h00, 8'h02, 8'h02);
    wt(2);
    chk({6'h00, pin_oe_n[1:0]}, 8'h02);
    rd(8'h00, 8'hA5);
    // group 1 pin 8: alternate output hides the latch
    wr(8'h09, 8'h00, 8'h01);
    wr(8'h08, 8'h01, 8'h01);
    wr(8'h0A, 8'h01, 8'h01);
    rd(8'h08, 8'h00);
    @(posedge clk);
    alt_out[8] <= 1'b1;
    wt(2);
    chk({7'h00, pin_out[8]}, 8'h01);
    rd(8'h08, 8'h01);
    @(posedge clk);
    alt_out[8] <= 1'b0;
    ext_level[9] <= 1'b1;
    wr(8'h0A, 8'h02, 8'h03);
    rd(8'h08, 8'h03);
    chk({7'h00, alt_in[9]}, 8'h01);
    // pin 0 alternate codes, all four
    wr(8'h01, 8'h01, 8'h01);
    wr(8'h02, 8'h01, 8'h01);
    @(posedge clk);
    ext_level[0] <= 1'b1;
    pin0_timer_output <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      wr(8'h03, {7'h00, c[1]}, 8'h01);
      wr(8'h04, {7'h00, c[0]}, 8'h01);
      wt(4);
      chk({4'h0, pin0_capture_interrupt, pin0_timer_input, pin0_event_input,
        pin0_interrupt_input}, fn_exp[c]);
      rd(8'h80, (c == 3) ? 8'h02 : 8'h00);
    end
    wr(8'h01, 8'h00, 8'h01);
    wt(2);
    chk({7'h00, pin_oe_n[0]}, 8'h01);
    wr(8'h03, 8'h00, 8'h01);
    wt(2);
    chk({pin_out[0], pin_oe_n[0]}, 8'h02);
    rd(8'h00, 8'hA5);
    // absent registers and an unmapped place stay silent
    for (int i = 0; i < 5; i++) begin
      wr(gone[i], 8'hFF, 8'hFF);
      rd(gone[i], 8'h00);
    end
    // group 6 has no direction register: a clear must not drive, alt input still works
    wr(8'h31, 8'h00, 8'hFF);
    wr(8'h32, 8'h01, 8'h01);
    @(posedge clk);
    ext_level[48] <= 1'b1;
    wt(4);
    chk(pin_oe_n[55:48], 8'hFF);
    chk({7'h00, alt_in[48]}, 8'h01);
    wr(8'h64, 8'h5A, 8'hFF);
    rd(8'h64, 8'h5A);
    // debug takeover of pins 6 and 7
    wr(8'h00, 8'hC0, 8'hC0);
    wr(8'h01, 8'h00, 8'hC0);
    @(posedge clk);
    ext_level[7:6] <= 2'h1;
    test_reset <= 1'b1;
    wt(8);
    chk({6'h00, pin_oe_n[7:6]}, 8'h03);
    chk({6'h00, debug_tck, debug_tms}, 8'h01);
    rd(8'h80, 8'h01);
    @(posedge clk);
    test_reset <= 1'b0;
    wt(6);
    chk({pin_oe_n[7:6], pin_out[7:6]}, 8'h03);
    finish_test();
  end
endmodule : tb_port_pin_function_control

bind ppfc_top ppfc_checker i_ppfc_checker (.clk, .rst, .bus_addr, .bus_rd, .bus_rdata,
  .pin_out, .pin_oe_n, .alt_out, .alt_in, .alt_mode, .alt_fsel, .alt_fselx, .test_reset,
  .debug_tms, .debug_tck, .pin0_interrupt_input, .pin0_event_input);
